/* power_up_strap_loader.sv */
// power-up strap loader: captures board straps at reset release, decodes mode,
// and shows the latched configuration over apb
// assumes pclk at 125 mhz, presetn asynchronous active low, apb3 master
// Function
// - three strap pins captured at reset release form the low three station address bits.
// - a pulled-up address strap records a one and a pulled-down strap records a zero.
// - the upper two bits of the five-bit station address are always zero.
// - a four-bit mode code is captured from four straps at reset and decoded to a mode.
// - code 0111 powers the chip down and code 0100 selects the pin-chain test.
// - code 1100 selects reduced-pin gigabit interface advertising gigabit full duplex only.
// - code 1101 selects gigabit interface advertising gigabit full and half duplex only.
// - code 1110 advertises all but gigabit half duplex and code 1111 advertises everything.
// - the reference clock output is enabled when its strap is pulled up and disabled otherwise.
// - a pulled-up style strap selects single indication and pulled-down selects tri-color dual.
// - all straps are captured at the rising edge of the active-low chip reset.
module power_up_strap_loader
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // shared strap pins
    input  wire logic [2:0]  addr_pin_in,
    input  wire logic [3:0]  code_pin_in,
    input  wire logic        clk_en_pin_in,
    input  wire logic        led_pin_in,
    // decoded configuration
    output logic [4:0]       station_address_strap,
    output logic             ref_clock_out_enable_strap,
    output logic             indicator_style_strap,
    output logic             power_down,
    output logic             pin_test_mode,
    output logic             gmii_mode,
    output logic [5:0]       advertise
);

    ////////////////////////////////////////////////////////////////////////////
    // synchroniser

    strap_if pins ();

    strap_sync u_sync
    (
        .pclk          (pclk),
        .presetn       (presetn),
        .addr_pin_in   (addr_pin_in),
        .code_pin_in   (code_pin_in),
        .clk_en_pin_in (clk_en_pin_in),
        .led_pin_in    (led_pin_in),
        .pins          (pins)
    );

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic strap_pkg::op_mode_e decode_mode(input logic [3:0] code);
        strap_pkg::op_mode_e m;
        m = strap_pkg::mode_reserved;
        case (code)
            strap_pkg::code_pin_test:   m = strap_pkg::mode_pin_test;
            strap_pkg::code_power_down: m = strap_pkg::mode_power_down;
            strap_pkg::code_gig_fd:     m = strap_pkg::mode_gig_fd;
            strap_pkg::code_gig_fhd:    m = strap_pkg::mode_gig_fhd;
            strap_pkg::code_all_no_gh:  m = strap_pkg::mode_all_no_gh;
            strap_pkg::code_all:        m = strap_pkg::mode_all;
            default:                    m = strap_pkg::mode_reserved;
        endcase
        return m;
    endfunction

    function automatic logic [5:0] adv_of(input strap_pkg::op_mode_e m);
        logic [5:0] a;
        a = strap_pkg::adv_none;
        case (m)
            strap_pkg::mode_gig_fd:    a = strap_pkg::adv_1000f;
            strap_pkg::mode_gig_fhd:   a = strap_pkg::adv_1000hf;
            strap_pkg::mode_all_no_gh: a = strap_pkg::adv_all_no1000h;
            strap_pkg::mode_all:       a = strap_pkg::adv_all;
            default:                   a = strap_pkg::adv_none;
        endcase
        return a;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    // capture waits for the synchroniser to fill with post-release pin levels
    typedef enum logic [1:0] {
        st_fill0,
        st_fill1,
        st_capture,
        st_hold
    } cap_e;

    typedef struct packed {
        cap_e                 cap;
        logic [2:0]           addr;
        logic [3:0]           code;
        logic                 clk_en;
        logic                 led;
        strap_pkg::op_mode_e  mode;
        logic [31:0]          rdata;
        logic                 ready;
        logic                 slverr;
    } loader_s;

    loader_s state_q;
    loader_s state_d;

    logic access;
    assign access = psel && penable && !state_q.ready;

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        state_d        = state_q;
        state_d.ready  = 1'b0;
        state_d.slverr = 1'b0;
        case (state_q.cap)
            st_fill0:
            begin
                state_d.cap = st_fill1;
            end
            st_fill1:
            begin
                state_d.cap = st_capture;
            end
            st_capture:
            begin
                state_d.addr   = pins.addr_pins;
                state_d.code   = pins.code_pins;
                state_d.clk_en = pins.clk_en_pin;
                state_d.led    = pins.led_pin;
                state_d.mode   = decode_mode(pins.code_pins);
                state_d.cap    = st_hold;
            end
            st_hold:
            begin
                state_d.cap = st_hold;
            end
            default:
            begin
                state_d.cap = st_hold;
            end
        endcase

        // registers are read-only; writes are refused with an error
        if (access)
        begin
            state_d.ready = 1'b1;
            state_d.rdata = '0;
            if (pwrite)
            begin
                state_d.slverr = 1'b1;
            end
            else
            begin
                case (paddr)
                    strap_pkg::straps_off:
                    begin
                        state_d.rdata[strap_pkg::addr_msb:strap_pkg::addr_lsb] =
                            {strap_pkg::addr_upper_zero, state_q.addr};
                        state_d.rdata[strap_pkg::clk_en_bit]    = state_q.clk_en;
                        state_d.rdata[strap_pkg::led_style_bit] = state_q.led;
                        state_d.rdata[strap_pkg::code_msb:strap_pkg::code_lsb] = state_q.code;
                    end
                    strap_pkg::mode_off:
                    begin
                        state_d.rdata[strap_pkg::adv_msb:strap_pkg::adv_lsb] = adv_of(state_q.mode);
                        state_d.rdata[strap_pkg::power_down_bit] = (state_q.mode == strap_pkg::mode_power_down);
                        state_d.rdata[strap_pkg::pin_test_bit]   = (state_q.mode == strap_pkg::mode_pin_test);
                        state_d.rdata[strap_pkg::gmii_bit]       = (adv_of(state_q.mode) != strap_pkg::adv_none);
                        state_d.rdata[strap_pkg::reserved_bit]   = (state_q.mode == strap_pkg::mode_reserved);
                        state_d.rdata[strap_pkg::mode_enum_msb:strap_pkg::mode_enum_lsb] = state_q.mode;
                    end
                    strap_pkg::pin_status_off:
                    begin
                        state_d.rdata[8:0] = {pins.led_pin, pins.clk_en_pin, pins.code_pins, pins.addr_pins};
                    end
                    default:
                    begin
                        state_d.slverr = 1'b1;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers and outputs

    logic [4:0] station_address_d;
    assign station_address_d = {strap_pkg::addr_upper_zero, state_d.addr};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q.cap                <= st_fill0;
            state_q.addr               <= strap_pkg::addr_rst;
            state_q.code               <= strap_pkg::code_rst;
            state_q.clk_en             <= 1'b0;
            state_q.led                <= 1'b0;
            state_q.mode               <= strap_pkg::mode_reserved;
            state_q.rdata              <= '0;
            state_q.ready              <= 1'b0;
            state_q.slverr             <= 1'b0;
            station_address_strap      <= '0;
            ref_clock_out_enable_strap <= 1'b0;
            indicator_style_strap      <= 1'b0;
            power_down                 <= 1'b0;
            pin_test_mode              <= 1'b0;
            gmii_mode                  <= 1'b0;
            advertise                  <= strap_pkg::adv_none;
            prdata                     <= '0;
            pready                     <= 1'b0;
            pslverr                    <= 1'b0;
        end
        else
        begin
            state_q                    <= state_d;
            station_address_strap      <= station_address_d;
            ref_clock_out_enable_strap <= state_d.clk_en;
            indicator_style_strap      <= state_d.led;
            power_down                 <= (state_d.mode == strap_pkg::mode_power_down);
            pin_test_mode              <= (state_d.mode == strap_pkg::mode_pin_test);
            gmii_mode                  <= (adv_of(state_d.mode) != strap_pkg::adv_none);
            advertise                  <= adv_of(state_d.mode);
            prdata                     <= state_d.rdata;
            pready                     <= state_d.ready;
            pslverr                    <= state_d.slverr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // capture and the latched configuration
    sequence captured_s;
        state_q.cap == st_capture;
    endsequence

    sequence held_s;
        state_q.cap == st_hold;
    endsequence

    sequence release_s;
        $rose(presetn);
    endsequence

    sequence config_still_s;
        $stable(station_address_strap) && $stable(ref_clock_out_enable_strap) && $stable(indicator_style_strap);
    endsequence

    capture_edge_a: assert property (release_s |-> ##2 captured_s)
        else $error("straps not captured on the third edge after reset release");
    addr_capture_a: assert property (
        captured_s |=> ##1 station_address_strap[2:0] == $past(pins.addr_pins, 2))
        else $error("station address not taken from straps");
    addr_upper_a: assert property (station_address_strap[4:3] == strap_pkg::addr_upper_zero)
        else $error("station address upper bits not zero");
    power_down_a: assert property (
        captured_s ##1 (state_q.code == strap_pkg::code_power_down) |=> power_down)
        else $error("power-down code not decoded");
    pin_test_a: assert property (pin_test_mode |-> state_q.code == strap_pkg::code_pin_test)
        else $error("pin test without its code");
    gig_fd_a: assert property (
        held_s ##0 (state_q.code == strap_pkg::code_gig_fd) |=> advertise == strap_pkg::adv_1000f)
        else $error("gigabit full-duplex advertisement wrong");
    gig_fhd_a: assert property (
        held_s ##0 (state_q.code == strap_pkg::code_gig_fhd) |=> advertise == strap_pkg::adv_1000hf)
        else $error("gigabit full and half advertisement wrong");
    adv_all_a: assert property (
        held_s ##0 (state_q.code == strap_pkg::code_all) |=> advertise == strap_pkg::adv_all && gmii_mode)
        else $error("full advertisement wrong");
    all_no_gh_a: assert property (
        held_s ##0 (state_q.code == strap_pkg::code_all_no_gh) |=>
            advertise == strap_pkg::adv_all_no1000h && gmii_mode)
        else $error("advertisement without gigabit half-duplex wrong");
    gig_only_a: assert property (
        held_s ##0 (state_q.code == strap_pkg::code_gig_fd) |=> gmii_mode && !power_down && !pin_test_mode)
        else $error("reduced-pin gigabit mode not selected");
    clk_en_a: assert property (
        captured_s |=> ##1 ref_clock_out_enable_strap == $past(pins.clk_en_pin, 2))
        else $error("clock enable strap not latched");
    led_style_a: assert property (
        captured_s |=> ##1 indicator_style_strap == $past(pins.led_pin, 2))
        else $error("indicator style strap not latched");
    straps_hold_a: assert property (
        held_s |=> $stable(state_q.addr) && $stable(state_q.code) && $stable(state_q.mode))
        else $error("latched straps changed after capture");
    config_hold_a: assert property (held_s |=> config_still_s)
        else $error("configuration outputs changed after capture");
    mode_alone_a: assert property (
        power_down |-> !pin_test_mode && !gmii_mode && advertise == strap_pkg::adv_none)
        else $error("power-down shares its mode with another");
    reserved_quiet_a: assert property (
        state_q.mode == strap_pkg::mode_reserved |-> !power_down && !pin_test_mode && !gmii_mode)
        else $error("reserved code selected a mode");

    // apb answers
    sequence apb_access_s;
        psel && penable && !pready;
    endsequence

    sequence apb_answer_s;
        pready ##1 !pready;
    endsequence

    apb_wait_a: assert property (apb_access_s |=> apb_answer_s)
        else $error("apb answer not a single pulse after one wait state");
    ready_only_a: assert property (pready |-> $past(psel) && $past(penable))
        else $error("ready without an access");
    slverr_ready_a: assert property (pslverr |-> pready)
        else $error("error flag outside an answer");
    write_refused_a: assert property (apb_access_s ##0 pwrite |=> pslverr)
        else $error("write not refused");
    unmapped_refused_a: assert property (
        apb_access_s ##0 (paddr != strap_pkg::straps_off && paddr != strap_pkg::mode_off &&
            paddr != strap_pkg::pin_status_off) |=> pslverr)
        else $error("unmapped address not refused");
    read_good_a: assert property (
        apb_access_s ##0 (!pwrite && paddr == strap_pkg::mode_off) |=> !pslverr)
        else $error("mode read refused");

endmodule

/* strap_pkg.sv */
// shared constants for the power-up strap loader
// assumes a single pclk domain and an apb master on the register side
package strap_pkg;

    localparam int addr_width        = 12;
    localparam int data_width        = 32;

    // register byte addresses
    localparam logic [11:0] straps_off     = 12'h000;
    localparam logic [11:0] mode_off       = 12'h004;
    localparam logic [11:0] pin_status_off = 12'h008;

    // field positions in the straps register
    localparam int addr_lsb          = 0;
    localparam int addr_msb          = 4;
    localparam int clk_en_bit        = 8;
    localparam int led_style_bit     = 9;
    localparam int code_lsb          = 12;
    localparam int code_msb          = 15;

    // field positions in the mode register
    localparam int adv_lsb           = 0;
    localparam int adv_msb           = 5;
    localparam int power_down_bit    = 8;
    localparam int pin_test_bit      = 9;
    localparam int gmii_bit          = 10;
    localparam int reserved_bit      = 11;
    localparam int mode_enum_lsb     = 16;
    localparam int mode_enum_msb     = 18;

    // advertised ability bits: 10h 10f 100h 100f 1000h 1000f
    localparam logic [5:0] adv_1000f      = 6'h20;
    localparam logic [5:0] adv_1000hf     = 6'h30;
    localparam logic [5:0] adv_all_no1000h = 6'h2f;
    localparam logic [5:0] adv_all        = 6'h3f;
    localparam logic [5:0] adv_none       = 6'h00;

    // mode strap codes
    localparam logic [3:0] code_pin_test   = 4'h4;
    localparam logic [3:0] code_power_down = 4'h7;
    localparam logic [3:0] code_gig_fd     = 4'hc;
    localparam logic [3:0] code_gig_fhd    = 4'hd;
    localparam logic [3:0] code_all_no_gh  = 4'he;
    localparam logic [3:0] code_all        = 4'hf;

    localparam logic [1:0] addr_upper_zero = 2'h0;

    // reset values of the capture registers
    localparam logic [2:0] addr_rst   = 3'h0;
    localparam logic [3:0] code_rst   = 4'h0;

    typedef enum logic [2:0] {
        mode_reserved,
        mode_pin_test,
        mode_power_down,
        mode_gig_fd,
        mode_gig_fhd,
        mode_all_no_gh,
        mode_all
    } op_mode_e;

endpackage

/* strap_if.sv */
// carries synchronised strap pin levels from the pin stage to the loader
// assumes both ends run on pclk
interface strap_if;
    logic [2:0] addr_pins;
    logic [3:0] code_pins;
    logic       clk_en_pin;
    logic       led_pin;

    modport src (output addr_pins, output code_pins, output clk_en_pin, output led_pin);
    modport dst (input  addr_pins, input  code_pins, input  clk_en_pin, input  led_pin);
endinterface

/* strap_sync.sv */
// two-flop synchroniser for the shared strap pins
// assumes pins are asynchronous to pclk
module strap_sync
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // raw pins
    input  wire logic [2:0] addr_pin_in,
    input  wire logic [3:0] code_pin_in,
    input  wire logic       clk_en_pin_in,
    input  wire logic       led_pin_in,
    // synchronised levels
    strap_if.src            pins
);

    typedef struct packed {
        logic [8:0] meta;
        logic [8:0] sync;
    } sync_s;

    sync_s state_q;
    sync_s state_d;

    always_comb
    begin
        state_d      = state_q;
        state_d.meta = {led_pin_in, clk_en_pin_in, code_pin_in, addr_pin_in};
        state_d.sync = state_q.meta;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign pins.addr_pins  = state_q.sync[2:0];
    assign pins.code_pins  = state_q.sync[6:3];
    assign pins.clk_en_pin = state_q.sync[7];
    assign pins.led_pin    = state_q.sync[8];

endmodule

/* strap_board.sv */
// board side of the strap pins: pull resistors, then mac traffic after capture
// assumes the bench raises traffic only once the straps have been captured
module strap_board
(
    // clock
    input  wire logic       pclk,
    // strap settings {style, clock enable, code, address} and mac activity
    input  wire logic [8:0] pulls,
    input  wire logic       traffic,
    // shared pins
    output logic      [2:0] addr_pin,
    output logic      [3:0] code_pin,
    output logic            clk_en_pin,
    output logic            led_pin
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [8:0] noise_q = 9'h0a5;

    // pins carry changing interface data once the straps are taken
    always @(posedge pclk)
        noise_q <= {noise_q[7:0], noise_q[8] ^ noise_q[4]};

    // resistors overpower any mac drive while the straps are sampled
    assign {led_pin, clk_en_pin, code_pin, addr_pin} = traffic ? noise_q : pulls;
endmodule

/* power_up_strap_loader_tb.sv */
// self-checking bench for the strap loader: random straps, each of the six defined mode codes
// assumes the design answers apb reads with one wait state
module power_up_strap_loader_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [8:0]  pulls = 9'h000;
    logic        traffic = 1'b0;
    logic [2:0]  addr_pin;
    logic [3:0]  code_pin;
    logic        clk_en_pin;
    logic        led_pin;
    logic [4:0]  station_address_strap;
    logic        ref_clock_out_enable_strap;
    logic        indicator_style_strap;
    logic        power_down;
    logic        pin_test_mode;
    logic        gmii_mode;
    logic [5:0]  advertise;
    int          miscompares = 0;
    int          checks = 0;

    always #4 pclk = ~pclk;

    strap_board board (.pclk(pclk), .pulls(pulls), .traffic(traffic), .addr_pin(addr_pin),
        .code_pin(code_pin), .clk_en_pin(clk_en_pin), .led_pin(led_pin));

    power_up_strap_loader dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .addr_pin_in(addr_pin), .code_pin_in(code_pin),
        .clk_en_pin_in(clk_en_pin), .led_pin_in(led_pin),
        .station_address_strap(station_address_strap),
        .ref_clock_out_enable_strap(ref_clock_out_enable_strap),
        .indicator_style_strap(indicator_style_strap), .power_down(power_down),
        .pin_test_mode(pin_test_mode), .gmii_mode(gmii_mode), .advertise(advertise));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // caller stands just after a rising edge; returns at the edge that samples pready high, bus still held
    task automatic apb(input logic [11:0] a, input logic wr, output logic [31:0] rd, output logic err);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= $urandom;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1);
        check(32'(n), 32'h2);
        rd = prdata;
        err = pslverr;
    endtask

    task automatic apb_idle;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // advertised abilities: bit0 10h .. bit5 1000f
    function automatic logic [5:0] adv_of(input logic [3:0] c);
        case (c)
            4'hc:    return 6'h20;
            4'hd:    return 6'h30;
            4'he:    return 6'h2f;
            4'hf:    return 6'h3f;
            default: return 6'h00;
        endcase
    endfunction

    function automatic logic [2:0] idx_of(input logic [3:0] c);
        case (c)
            4'h4:    return 3'h1;
            4'h7:    return 3'h2;
            4'hc:    return 3'h3;
            4'hd:    return 3'h4;
            4'he:    return 3'h5;
            4'hf:    return 3'h6;
            default: return 3'h0;
        endcase
    endfunction

    initial
    begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        report_and_stop();
    end

    initial
    begin
        logic [3:0]  codes [6];
        logic [2:0]  a;
        logic        ce;
        logic        led;
        logic        g;
        logic [31:0] rd;
        logic [31:0] st;
        logic        err;
        logic [8:0]  p;
        void'($urandom(32'hfc11));
        codes = '{4'h4, 4'h7, 4'hc, 4'hd, 4'he, 4'hf};
        foreach (codes[i])
        begin
            a = 3'($urandom_range(7, 1));
            ce = 1'($urandom);
            led = 1'($urandom);
            g = codes[i][3];
            @(posedge pclk);
            presetn <= 1'b0;
            traffic <= 1'b0;
            pulls <= {led, ce, codes[i], a};
            repeat (20) @(posedge pclk);
            check(32'({station_address_strap, power_down, pin_test_mode, gmii_mode, advertise}), 32'h0);
            presetn <= 1'b1;
            repeat (4) @(posedge pclk);
            traffic <= 1'b1;
            repeat (30) @(posedge pclk);
            check(32'(station_address_strap), {29'h0, a});
            check(32'(ref_clock_out_enable_strap), 32'(ce));
            check(32'(indicator_style_strap), 32'(led));
            check(32'({power_down, pin_test_mode}), 32'({codes[i] == 4'h7, codes[i] == 4'h4}));
            check(32'({gmii_mode, advertise}), 32'({g, adv_of(codes[i])}));
            apb(12'h000, 1'b0, st, err);
            check(st, 32'({codes[i], 2'b00, led, ce, 3'b000, 2'b00, a}));
            check(32'(err), 32'h0);
            apb(12'h004, 1'b0, rd, err);
            apb_idle();
            check(rd, 32'({idx_of(codes[i]), 5'h00, g, codes[i] == 4'h4, codes[i] == 4'h7, 2'b00,
                adv_of(codes[i])}));
            check(32'(err), 32'h0);
        end
        @(posedge pclk);
        apb(12'h000, 1'b1, rd, err);
        check(32'(err), 32'h1);
        apb(12'h00c, 1'b0, rd, err);
        check(32'(err), 32'h1);
        apb(12'h002, 1'b0, rd, err);
        check(32'(err), 32'h1);
        apb_idle();
        // pins take new levels while the latched straps keep the old ones
        p = 9'($urandom);
        traffic <= 1'b0;
        pulls <= p;
        repeat (3) @(posedge pclk);
        apb(12'h008, 1'b0, rd, err);
        check(rd, 32'(p));
        check(32'(err), 32'h0);
        apb(12'h000, 1'b0, rd, err);
        apb_idle();
        check(rd, st);
        repeat (2) @(posedge pclk);
        report_and_stop();
    end
endmodule
